// *** src/pts_pkg.sv ***
package pts_pkg;
  // register word byte addresses on the avalon slave
  localparam logic [3:0] PTS_OFF_TRIG_SEL = 4'h0;
  localparam logic [3:0] PTS_OFF_UPPER_EN = 4'h4;
  localparam logic [3:0] PTS_OFF_LOWER_EN = 4'h8;
  localparam logic [3:0] PTS_OFF_OVL_MODE = 4'hC;
  localparam logic [3:0] PTS_OFF_NEXT_DATA = 4'h0;
  localparam logic [3:0] PTS_OFF_PIN_STATE = 4'h4;
  // second page of registers selected by address bit 4
  localparam int PTS_PAGE_BIT = 4;
  // reset values
  localparam logic [7:0] PTS_RST_TRIG_SEL = 8'hFF;
  localparam logic [7:0] PTS_RST_UPPER_EN = 8'h00;
  localparam logic [7:0] PTS_RST_LOWER_EN = 8'h00;
  localparam logic [3:0] PTS_RST_OVL_MODE = 4'h0;
  localparam logic [15:0] PTS_RST_NEXT_DATA = 16'h0000;
  localparam logic [15:0] PTS_RST_PINS = 16'h0000;
  // select field positions, two bits per group
  localparam int PTS_SEL_W = 2;
  localparam int PTS_GRP_W = 4;
  localparam int PTS_NUM_GRP = 4;
  localparam int PTS_NUM_CHAN = 4;

  typedef struct packed {
    logic [PTS_NUM_CHAN-1:0] match_a;
    logic [PTS_NUM_CHAN-1:0] match_b;
  } pts_match_t;

  typedef enum logic [1:0] {
    PTS_CH0,
    PTS_CH1,
    PTS_CH2,
    PTS_CH3
  } pts_chan_t;
endpackage

// *** src/pts_group_trigger.sv ***
`timescale 1ns/100ps
// one group: picks its timer channel and forms its load strobes
module pts_group_trigger
  import pts_pkg::*;
(
  input wire logic [PTS_SEL_W-1:0] chan_sel_in,
  input wire logic nonoverlap_in,
  input wire pts_match_t match_in,
  output logic load_out,
  output logic clear_out
);
  logic hit_a;
  logic hit_b;

  always_comb
  begin
    case (pts_chan_t'(chan_sel_in))
      PTS_CH0:
      begin
        hit_a = match_in.match_a[0];
        hit_b = match_in.match_b[0];
      end
      PTS_CH1:
      begin
        hit_a = match_in.match_a[1];
        hit_b = match_in.match_b[1];
      end
      PTS_CH2:
      begin
        hit_a = match_in.match_a[2];
        hit_b = match_in.match_b[2];
      end
      PTS_CH3:
      begin
        hit_a = match_in.match_a[3];
        hit_b = match_in.match_b[3];
      end
      default:
      begin
        hit_a = 1'b0;
        hit_b = 1'b0;
      end
    endcase
  end

  // match a loads in both modes; in non-overlap mode match b first drives
  // the bits that are about to change low so edges never overlap
  assign load_out = hit_a;
  assign clear_out = nonoverlap_in & hit_b;
endmodule

// *** src/pts_trigger_select.sv ***
`timescale 1ns/100ps
module pts_trigger_select
  import pts_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [1:0] avs_response_out,
  input wire pts_match_t match_in,
  output logic [7:0] porta_pins_out,
  output logic [7:0] portb_pins_out
);
  logic [7:0] group_trigger_select;
  logic [7:0] upper_output_enable;
  logic [7:0] lower_output_enable;
  logic [3:0] group_overlap_mode_reg;
  logic [15:0] next_data;
  logic [15:0] pins;
  logic [15:0] next_pins;
  logic [PTS_NUM_GRP-1:0] grp_load;
  logic [PTS_NUM_GRP-1:0] grp_clear;
  logic access_done;
  logic req;
  logic page;
  logic [3:0] offs;
  logic hit;

  // one wait state: the answer is given one edge after the request appears
  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~access_done;
  assign page = avs_address_in[PTS_PAGE_BIT];
  assign offs = avs_address_in[3:0];

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
                                            input logic be);
    merge_byte = be ? wd[7:0] : old;
  endfunction

  always_comb
  begin
    hit = 1'b1;
    if (!page)
    begin
      case (offs)
        PTS_OFF_TRIG_SEL, PTS_OFF_UPPER_EN, PTS_OFF_LOWER_EN, PTS_OFF_OVL_MODE: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
    else
    begin
      case (offs)
        PTS_OFF_NEXT_DATA, PTS_OFF_PIN_STATE: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      access_done <= 1'b0;
    else
      access_done <= req & ~access_done;
  end

  wire logic wr_go = avs_write_in & access_done;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      group_trigger_select <= PTS_RST_TRIG_SEL;
      upper_output_enable <= PTS_RST_UPPER_EN;
      lower_output_enable <= PTS_RST_LOWER_EN;
      group_overlap_mode_reg <= PTS_RST_OVL_MODE;
      next_data <= PTS_RST_NEXT_DATA;
    end
    else if (wr_go && !page)
    begin
      case (offs)
        PTS_OFF_TRIG_SEL:
          group_trigger_select <= merge_byte(group_trigger_select, avs_writedata_in,
                                             avs_byteenable_in[0]);
        PTS_OFF_UPPER_EN:
          upper_output_enable <= merge_byte(upper_output_enable, avs_writedata_in,
                                            avs_byteenable_in[0]);
        PTS_OFF_LOWER_EN:
          lower_output_enable <= merge_byte(lower_output_enable, avs_writedata_in,
                                            avs_byteenable_in[0]);
        PTS_OFF_OVL_MODE:
          if (avs_byteenable_in[0])
            group_overlap_mode_reg <= avs_writedata_in[3:0];
        default: ;
      endcase
    end
    else if (wr_go && offs == PTS_OFF_NEXT_DATA)
    begin
      next_data[7:0] <= merge_byte(next_data[7:0], avs_writedata_in, avs_byteenable_in[0]);
      next_data[15:8] <= merge_byte(next_data[15:8], avs_writedata_in >> 8,
                                    avs_byteenable_in[1]);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      avs_readdata_out <= 32'h00000000;
    else if (avs_read_in && !access_done)
    begin
      avs_readdata_out <= 32'h00000000;
      if (!page)
      begin
        case (offs)
          PTS_OFF_TRIG_SEL: avs_readdata_out[7:0] <= group_trigger_select;
          PTS_OFF_UPPER_EN: avs_readdata_out[7:0] <= upper_output_enable;
          PTS_OFF_LOWER_EN: avs_readdata_out[7:0] <= lower_output_enable;
          PTS_OFF_OVL_MODE: avs_readdata_out[3:0] <= group_overlap_mode_reg;
          default: ;
        endcase
      end
      else if (offs == PTS_OFF_NEXT_DATA)
        avs_readdata_out[15:0] <= next_data;
      else if (offs == PTS_OFF_PIN_STATE)
        avs_readdata_out[15:0] <= pins;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      avs_response_out <= 2'h0;
    else if (req && !access_done)
      avs_response_out <= hit ? 2'h0 : 2'h2;
  end

  for (genvar g = 0; g < PTS_NUM_GRP; g++)
  begin : g_grp
    pts_group_trigger u_trig (
      .chan_sel_in(group_trigger_select[g*PTS_SEL_W +: PTS_SEL_W]),
      .nonoverlap_in(group_overlap_mode_reg[g]),
      .match_in(match_in),
      .load_out(grp_load[g]),
      .clear_out(grp_clear[g])
    );
  end

  always_comb
  begin
    logic [15:0] en;
    en = {upper_output_enable, lower_output_enable};
    next_pins = pins;
    for (int g = 0; g < PTS_NUM_GRP; g++)
    begin
      for (int b = 0; b < PTS_GRP_W; b++)
      begin
        if (en[g*PTS_GRP_W+b])
        begin
          // match a loads, match b pre-clears
          if (grp_load[g])
            next_pins[g*PTS_GRP_W+b] = next_data[g*PTS_GRP_W+b];
          else if (grp_clear[g] && pins[g*PTS_GRP_W+b] != next_data[g*PTS_GRP_W+b])
            next_pins[g*PTS_GRP_W+b] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      pins <= PTS_RST_PINS;
    else
      pins <= next_pins;
  end

  assign porta_pins_out = pins[7:0];
  assign portb_pins_out = pins[15:8];

  a_upper_blocked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !upper_output_enable[7] |=> $stable(portb_pins_out[7]))
    else $error("disabled upper bit changed");
  a_upper_copy: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (upper_output_enable[0] && grp_load[2]) |=> portb_pins_out[0] == $past(next_data[8]))
    else $error("enabled upper bit not copied");
  a_lower_copy: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (lower_output_enable[4] && grp_load[1]) |=> porta_pins_out[4] == $past(next_data[4]))
    else $error("enabled lower bit not copied");
  a_grp0_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    grp_load[0] == match_in.match_a[group_trigger_select[1:0]])
    else $error("group 0 trigger wrong");
  a_grp1_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    grp_load[1] == match_in.match_a[group_trigger_select[3:2]])
    else $error("group 1 trigger wrong");
  a_grp2_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    grp_load[2] == match_in.match_a[group_trigger_select[5:4]])
    else $error("group 2 trigger wrong");
  a_grp3_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    grp_load[3] == match_in.match_a[group_trigger_select[7:6]])
    else $error("group 3 trigger wrong");
  a_normal_no_b: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !group_overlap_mode_reg[0] |-> !grp_clear[0])
    else $error("match b acted in normal mode");
  a_nov_b_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (grp_clear[0] && !grp_load[0] && lower_output_enable[0] && next_data[0] != pins[0])
    |=> !porta_pins_out[0])
    else $error("non-overlap pre-clear missed");
  a_idle_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (grp_load == 4'h0 && grp_clear == 4'h0) |=> $stable(pins))
    else $error("pins moved without trigger");
  a_enable_reset: assert property (@(posedge clk_in)
    $rose(rst_n_in) |-> upper_output_enable == 8'h00)
    else $error("upper enable not cleared by reset");

  c_upper_load: cover property (@(posedge clk_in) grp_load[3] && upper_output_enable != 8'h00);
  c_nov_clear: cover property (@(posedge clk_in) grp_clear != 4'h0);
  c_bus_write: cover property (@(posedge clk_in) wr_go);
endmodule

// *** testbench/pts_timer_model.sv ***
`timescale 1ns/100ps
// timer stand-in: one-cycle compare-match pulses on request
module pts_timer_model
  import pts_pkg::*;
(
  input wire logic clk_in,
  input wire logic [3:0] hit_a_in,
  input wire logic [3:0] hit_b_in,
  output pts_match_t match_out
);
  // registered so a pulse never lands in the edge that asked for it
  always_ff @(posedge clk_in)
  begin
    match_out.match_a <= hit_a_in;
    match_out.match_b <= hit_b_in;
  end
endmodule

// *** testbench/pts_trigger_select_tb.sv ***
`timescale 1ns/100ps
module pts_trigger_select_tb
  import pts_pkg::*;
;
  logic clk_in = 0;
  logic rst_n_in = 0;
  logic [4:0] adr = 0;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wd = 0;
  logic [3:0] be = 0;
  logic [31:0] rdata;
  logic wt;
  logic [1:0] resp;
  logic [1:0] rs;
  pts_match_t match;
  logic [7:0] pa;
  logic [7:0] pb;
  logic [3:0] ha = 0;
  logic [3:0] hb = 0;
  logic [31:0] q;
  logic [15:0] ev = 0;
  logic [15:0] nd;
  logic [7:0] s;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;

  pts_trigger_select u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wt), .avs_response_out(resp), .match_in(match),
    .porta_pins_out(pa), .portb_pins_out(pb));
  pts_timer_model u_tmr (.clk_in(clk_in), .hit_a_in(ha), .hit_b_in(hb),
    .match_out(match));

  initial
  begin
    forever #5 clk_in = ~clk_in;
  end

  task finish_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // a stuck handshake ends here instead of hanging
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      finish_test;
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] v);
    samples_checked++;
    if (v !== e)
    begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, v);
    end
  endtask

  // request stands until waitrequest is sampled low; data is taken at that edge
  // one idle edge after release keeps back-to-back calls from retoggling rd/wr
  task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    be <= 4'hF;
    rd <= !w;
    wr <= w;
    @(posedge clk_in);
    while (wt !== 1'b0)
      @(posedge clk_in);
    q = rdata;
    rs = resp;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_in);
  endtask

  task hit(input logic [3:0] a, input logic [3:0] b);
    ha <= a;
    hb <= b;
    @(posedge clk_in);
    ha <= 4'h0;
    hb <= 4'h0;
    repeat (4) @(posedge clk_in);
  endtask

  task t_reset;
    chk("pins", 32'h0, {pb, pa});
    acc(0, 5'h00, 0);
    chk("sel rst", 32'hFF, q);
    acc(0, 5'h04, 0);
    chk("upen rst", 32'h00, q);
  endtask

  task t_upper_rw;
    acc(1, 5'h04, 32'hA5);
    acc(0, 5'h04, 0);
    chk("upen a5", 32'hA5, q);
    acc(1, 5'h04, 32'h5A);
    acc(0, 5'h04, 0);
    chk("upen 5a", 32'h5A, q);
  endtask

  // only the group on channel c may move; the others sit on c+1
  task t_select;
    acc(1, 5'h04, 32'hFF);
    acc(1, 5'h08, 32'hFF);
    for (int g = 0; g < 4; g++)
      for (int c = 0; c < 4; c++)
      begin
        for (int h = 0; h < 4; h++)
          s[2*h+:2] = (h == g) ? 2'(c) : 2'(c + 1);
        nd = ~ev;
        acc(1, 5'h10, {16'h0, nd});
        acc(1, 5'h00, {24'h0, s});
        hit(4'h0, 4'(1 << c));
        chk("pins b", {16'h0, ev}, {pb, pa});
        hit(4'(1 << c), 4'h0);
        ev[4*g+:4] = nd[4*g+:4];
        chk("pins a", {16'h0, ev}, {pb, pa});
      end
    acc(0, 5'h14, 0);
    chk("pin reg", {16'h0, ev}, q);
  endtask

  task t_enable;
    acc(1, 5'h00, 32'h00);
    acc(1, 5'h04, 32'h0F);
    acc(1, 5'h08, 32'hF0);
    nd = ~ev;
    acc(1, 5'h10, {16'h0, nd});
    hit(4'h1, 4'h0);
    ev = (ev & 16'hF00F) | (nd & 16'h0FF0);
    chk("pins en", {16'h0, ev}, {pb, pa});
  endtask

  // low nibble 3 then next C: match b clears it, match a loads C
  task t_nonoverlap;
    acc(1, 5'h04, 32'hFF);
    acc(1, 5'h08, 32'hFF);
    acc(1, 5'h10, {16'h0, ev[15:4], 4'h3});
    hit(4'h1, 4'h0);
    ev[3:0] = 4'h3;
    acc(1, 5'h0C, 32'h1);
    acc(1, 5'h10, {16'h0, ev[15:4], 4'hC});
    hit(4'h0, 4'h1);
    chk("novl b", {16'h0, ev[15:4], 4'h0}, {pb, pa});
    hit(4'h1, 4'h0);
    chk("novl a", {16'h0, ev[15:4], 4'hC}, {pb, pa});
  endtask

  task t_unmapped;
    acc(0, 5'h18, 0);
    chk("bad rd", 32'h0, q);
    chk("bad rsp", 32'h2, {30'h0, rs});
  endtask

  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset;
    t_upper_rw;
    t_select;
    t_enable;
    t_nonoverlap;
    t_unmapped;
    finish_test;
  end
endmodule
